// ==== hdl/cir_map.vh ====
// Purpose: Register indices, masks and reset values of the core SFR bank
// Assumes: Byte address on the bus is four times the register index
// Notes:   Indices below the SFR window reach plain data memory
`ifndef CIR_MAP_VH
`define CIR_MAP_VH

`define CIR_ADDR_W         16
`define CIR_IDX_W          12
`define CIR_IDX_LSB        2
`define CIR_IDX_MSB        13
`define CIR_MEM_DEPTH      4096
`define CIR_SFR_BASE       12'hf80

`define CIR_STACK_TOP_UPPER    12'hfff
`define CIR_STACK_TOP_HIGH     12'hffe
`define CIR_STACK_TOP_LOW      12'hffd
`define CIR_RET_STACK_PTR      12'hffc
`define CIR_PC_LATCH_UPPER     12'hffb
`define CIR_PC_LATCH_HIGH      12'hffa
`define CIR_PC_LOW_BYTE        12'hff9
`define CIR_TBL_PTR_UPPER      12'hff8
`define CIR_TBL_PTR_HIGH       12'hff7
`define CIR_TBL_PTR_LOW        12'hff6
`define CIR_TBL_DATA_LATCH     12'hff5
`define CIR_PRODUCT_HIGH       12'hff4
`define CIR_PRODUCT_LOW        12'hff3
`define CIR_INT_CTRL_MAIN      12'hff2
`define CIR_INT_CTRL_EDGE      12'hff1
`define CIR_INT_CTRL_EXT       12'hff0
`define CIR_IND_PLAIN          12'hfef
`define CIR_IND_POST_INC       12'hfee
`define CIR_IND_POST_DEC       12'hfed
`define CIR_IND_PRE_INC        12'hfec
`define CIR_IND_OFFSET         12'hfeb
`define CIR_IND_PTR_HIGH       12'hfea
`define CIR_IND_PTR_LOW        12'hfe9
`define CIR_WORK_ACC           12'hfe8

`define CIR_MASK_5BIT          8'h1f
`define CIR_MASK_6BIT          8'h3f
`define CIR_MASK_4BIT          8'h0f
`define CIR_MASK_RETURN_STACK_POINTER        8'hdf
`define CIR_MASK_STK_FLAGS     8'hc0

`define CIR_RST_ZERO           8'h00
`define CIR_RST_PC_LATCH_UPPER 8'h20
`define CIR_RST_INT_CTRL_EDGE  8'hff
`define CIR_RST_INT_CTRL_EXT   8'hc0

`define CIR_RESP_OKAY          2'h0
`define CIR_RESP_SLVERR        2'h2

`endif

// ==== hdl/cir_core_regs.v ====
// Purpose: Core SFR bank with indirect pointer zero access locations
// Assumes: AXI4-Lite slave, 32-bit data, byte lane 0 carries the register
// Notes:   Data memory and SFRs share one 4096-byte index space
`timescale 1ns/1ps
`include "cir_map.vh"

// Operation
// - Plain indirect location accesses memory at pointer zero, pointer unchanged.
// - Indirect locations store nothing; accesses redirect to addressed memory byte.
// - Post-increment location uses pointer, then pointer increments by one.
// - Post-decrement location uses pointer, then pointer decrements by one.
module cir_core_regs (
  input  wire                    clk_sys,
  input  wire                    rst_n,
  input  wire [`CIR_ADDR_W-1:0]  s_axi_awaddr,
  input  wire [2:0]              s_axi_awprot,
  input  wire                    s_axi_awvalid,
  output wire                    s_axi_awready,
  input  wire [31:0]             s_axi_wdata,
  input  wire [3:0]              s_axi_wstrb,
  input  wire                    s_axi_wvalid,
  output wire                    s_axi_wready,
  output reg  [1:0]              s_axi_bresp,
  output reg                     s_axi_bvalid,
  input  wire                    s_axi_bready,
  input  wire [`CIR_ADDR_W-1:0]  s_axi_araddr,
  input  wire [2:0]              s_axi_arprot,
  input  wire                    s_axi_arvalid,
  output wire                    s_axi_arready,
  output reg  [31:0]             s_axi_rdata,
  output reg  [1:0]              s_axi_rresp,
  output reg                     s_axi_rvalid,
  input  wire                    s_axi_rready,
  output wire [11:0]             indirect_pointer_zero,
  output wire [7:0]              working_accumulator,
  output wire [7:0]              interrupt_control_main,
  output wire [7:0]              interrupt_control_edges_priority,
  output wire [7:0]              interrupt_control_external
);

  reg  [7:0]  data_mem [0:`CIR_MEM_DEPTH-1];
  reg  [7:0]  stack_top_upper_reg;
  reg  [7:0]  stack_top_high_reg;
  reg  [7:0]  stack_top_low_reg;
  reg  [7:0]  return_stack_pointer_reg;
  reg  [7:0]  pc_latch_upper_reg;
  reg  [7:0]  pc_latch_high_reg;
  reg  [7:0]  pc_low_byte_reg;
  reg  [7:0]  table_pointer_upper_reg;
  reg  [7:0]  table_pointer_high_reg;
  reg  [7:0]  table_pointer_low_reg;
  reg  [7:0]  table_data_latch_reg;
  reg  [7:0]  product_high_reg;
  reg  [7:0]  product_low_reg;
  reg  [7:0]  int_ctrl_main_reg;
  reg  [7:0]  int_ctrl_edge_reg;
  reg  [7:0]  int_ctrl_ext_reg;
  reg  [7:0]  ind_ptr_high_reg;
  reg  [7:0]  ind_ptr_low_reg;
  reg  [7:0]  work_acc_reg;

  reg  [11:0] ptr_next;
  reg  [11:0] eff_idx;
  reg         is_ind;
  reg  [7:0]  sfr_rd;
  reg  [7:0]  rd_byte;
  reg  [7:0]  ind_ptr_high_next;
  reg  [7:0]  ind_ptr_low_next;
  reg  [7:0]  work_acc_next;

  wire        wr_go;
  wire        rd_go;
  wire        wr_bad;
  wire        rd_bad;
  wire        wr_lane;
  wire        acc_bad;
  wire [11:0] aw_idx;
  wire [11:0] ar_idx;
  wire [11:0] acc_idx;
  wire [11:0] ptr;
  wire [11:0] acc_ext;
  wire [7:0]  wbyte;
  wire        mem_rd_sel;
  wire        mem_wr_sel;

  assign ptr     = {ind_ptr_high_reg[3:0], ind_ptr_low_reg};
  assign acc_ext = {{4{work_acc_reg[7]}}, work_acc_reg};
  assign aw_idx  = s_axi_awaddr[`CIR_IDX_MSB:`CIR_IDX_LSB];
  assign ar_idx  = s_axi_araddr[`CIR_IDX_MSB:`CIR_IDX_LSB];
  assign wr_bad  = |s_axi_awaddr[`CIR_ADDR_W-1:`CIR_IDX_MSB+1];
  assign rd_bad  = |s_axi_araddr[`CIR_ADDR_W-1:`CIR_IDX_MSB+1];
  assign wbyte   = s_axi_wdata[7:0];

  // Address and data are taken together, one write at a time
  assign wr_go         = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
  assign s_axi_awready = wr_go;
  assign s_axi_wready  = wr_go;
  // Write wins the shared access path; read waits one cycle
  assign rd_go         = s_axi_arvalid & ~s_axi_rvalid & ~wr_go;
  assign s_axi_arready = rd_go;

  assign acc_idx = wr_go ? aw_idx : ar_idx;
  assign acc_bad = wr_go ? wr_bad : rd_bad;
  assign wr_lane = wr_go & s_axi_wstrb[0] & ~wr_bad;
  // Direct data memory lies below the SFR window; indirect hits go anywhere
  assign mem_rd_sel = is_ind | (acc_idx < `CIR_SFR_BASE);
  assign mem_wr_sel = wr_lane & (is_ind | (aw_idx < `CIR_SFR_BASE));

  // Effective address and pointer side effect of the current access
  always @* begin
    is_ind   = 1'b1;
    eff_idx  = ptr;
    ptr_next = ptr;
    case (acc_idx)
      `CIR_IND_PLAIN: begin
        eff_idx = ptr;
      end
      `CIR_IND_POST_INC: begin
        ptr_next = ptr + 12'h001;
      end
      `CIR_IND_POST_DEC: begin
        ptr_next = ptr - 12'h001;
      end
      `CIR_IND_PRE_INC: begin
        eff_idx  = ptr + 12'h001;
        ptr_next = eff_idx;
      end
      `CIR_IND_OFFSET: begin
        eff_idx = ptr + acc_ext;
      end
      default: begin
        is_ind  = 1'b0;
        eff_idx = acc_idx;
      end
    endcase
  end

  // Indirect hits always land in the memory array, even above the SFR base
  always @* begin
    case (acc_idx)
      `CIR_STACK_TOP_UPPER: sfr_rd = stack_top_upper_reg;
      `CIR_STACK_TOP_HIGH:  sfr_rd = stack_top_high_reg;
      `CIR_STACK_TOP_LOW:   sfr_rd = stack_top_low_reg;
      `CIR_RET_STACK_PTR:   sfr_rd = return_stack_pointer_reg;
      `CIR_PC_LATCH_UPPER:  sfr_rd = pc_latch_upper_reg;
      `CIR_PC_LATCH_HIGH:   sfr_rd = pc_latch_high_reg;
      `CIR_PC_LOW_BYTE:     sfr_rd = pc_low_byte_reg;
      `CIR_TBL_PTR_UPPER:   sfr_rd = table_pointer_upper_reg;
      `CIR_TBL_PTR_HIGH:    sfr_rd = table_pointer_high_reg;
      `CIR_TBL_PTR_LOW:     sfr_rd = table_pointer_low_reg;
      `CIR_TBL_DATA_LATCH:  sfr_rd = table_data_latch_reg;
      `CIR_PRODUCT_HIGH:    sfr_rd = product_high_reg;
      `CIR_PRODUCT_LOW:     sfr_rd = product_low_reg;
      `CIR_INT_CTRL_MAIN:   sfr_rd = int_ctrl_main_reg;
      `CIR_INT_CTRL_EDGE:   sfr_rd = int_ctrl_edge_reg;
      `CIR_INT_CTRL_EXT:    sfr_rd = int_ctrl_ext_reg;
      `CIR_IND_PTR_HIGH:    sfr_rd = ind_ptr_high_reg;
      `CIR_IND_PTR_LOW:     sfr_rd = ind_ptr_low_reg;
      `CIR_WORK_ACC:        sfr_rd = work_acc_reg;
      default:              sfr_rd = `CIR_RST_ZERO;
    endcase
    if (mem_rd_sel)
      rd_byte = data_mem[eff_idx];
    else
      rd_byte = sfr_rd;
  end

  // Memory array has no reset; contents are undefined at power-up
  always @(posedge clk_sys) begin
    if (mem_wr_sel)
      data_mem[eff_idx] <= wbyte;
  end

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      stack_top_upper_reg      <= `CIR_RST_ZERO;
      stack_top_high_reg       <= `CIR_RST_ZERO;
      stack_top_low_reg        <= `CIR_RST_ZERO;
      return_stack_pointer_reg <= `CIR_RST_ZERO;
      pc_latch_upper_reg       <= `CIR_RST_PC_LATCH_UPPER;
      pc_latch_high_reg        <= `CIR_RST_ZERO;
      pc_low_byte_reg          <= `CIR_RST_ZERO;
      table_pointer_upper_reg  <= `CIR_RST_ZERO;
      table_pointer_high_reg   <= `CIR_RST_ZERO;
      table_pointer_low_reg    <= `CIR_RST_ZERO;
      table_data_latch_reg     <= `CIR_RST_ZERO;
      product_high_reg         <= `CIR_RST_ZERO;
      product_low_reg          <= `CIR_RST_ZERO;
      int_ctrl_main_reg        <= `CIR_RST_ZERO;
      int_ctrl_edge_reg        <= `CIR_RST_INT_CTRL_EDGE;
      int_ctrl_ext_reg         <= `CIR_RST_INT_CTRL_EXT;
    end else begin
      if (wr_lane && !is_ind) begin
        case (aw_idx)
          `CIR_STACK_TOP_UPPER:
            stack_top_upper_reg <= wbyte & `CIR_MASK_5BIT;
          `CIR_STACK_TOP_HIGH: stack_top_high_reg <= wbyte;
          `CIR_STACK_TOP_LOW:  stack_top_low_reg  <= wbyte;
          // Overflow/underflow flags can only be cleared by software
          `CIR_RET_STACK_PTR:
            return_stack_pointer_reg <= (wbyte & `CIR_MASK_5BIT) |
              (wbyte & return_stack_pointer_reg & `CIR_MASK_STK_FLAGS);
          `CIR_PC_LATCH_UPPER:
            pc_latch_upper_reg <= wbyte & `CIR_MASK_6BIT;
          `CIR_PC_LATCH_HIGH: pc_latch_high_reg <= wbyte;
          `CIR_PC_LOW_BYTE:   pc_low_byte_reg   <= wbyte;
          `CIR_TBL_PTR_UPPER:
            table_pointer_upper_reg <= wbyte & `CIR_MASK_6BIT;
          `CIR_TBL_PTR_HIGH:   table_pointer_high_reg <= wbyte;
          `CIR_TBL_PTR_LOW:    table_pointer_low_reg  <= wbyte;
          `CIR_TBL_DATA_LATCH: table_data_latch_reg   <= wbyte;
          `CIR_PRODUCT_HIGH:   product_high_reg       <= wbyte;
          `CIR_PRODUCT_LOW:    product_low_reg        <= wbyte;
          `CIR_INT_CTRL_MAIN:  int_ctrl_main_reg      <= wbyte;
          `CIR_INT_CTRL_EDGE:  int_ctrl_edge_reg      <= wbyte;
          `CIR_INT_CTRL_EXT:   int_ctrl_ext_reg       <= wbyte;
          default: begin
          end
        endcase
      end
    end
  end

  // Indirect side effect and direct byte writes never meet in one cycle
  always @* begin
    ind_ptr_high_next = ind_ptr_high_reg;
    ind_ptr_low_next  = ind_ptr_low_reg;
    if ((wr_go || rd_go) && is_ind && !acc_bad) begin
      ind_ptr_high_next = {4'h0, ptr_next[11:8]};
      ind_ptr_low_next  = ptr_next[7:0];
    end else if (wr_lane && aw_idx == `CIR_IND_PTR_HIGH) begin
      ind_ptr_high_next = wbyte & `CIR_MASK_4BIT;
    end else if (wr_lane && aw_idx == `CIR_IND_PTR_LOW) begin
      ind_ptr_low_next = wbyte;
    end
  end

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ind_ptr_high_reg <= `CIR_RST_ZERO;
      ind_ptr_low_reg  <= `CIR_RST_ZERO;
    end else begin
      ind_ptr_high_reg <= ind_ptr_high_next;
      ind_ptr_low_reg  <= ind_ptr_low_next;
    end
  end

  // Accumulator changes only on a direct write; offset reads leave it alone
  always @* begin
    work_acc_next = work_acc_reg;
    if (wr_lane && !is_ind && aw_idx == `CIR_WORK_ACC)
      work_acc_next = wbyte;
  end

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n)
      work_acc_reg <= `CIR_RST_ZERO;
    else
      work_acc_reg <= work_acc_next;
  end

  // Write response stands until the master takes it
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `CIR_RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_bad ? `CIR_RESP_SLVERR : `CIR_RESP_OKAY;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Read byte is captured at acceptance so later writes cannot disturb it
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rresp  <= `CIR_RESP_OKAY;
      s_axi_rdata  <= 32'h0000_0000;
    end else if (rd_go) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= rd_bad ? `CIR_RESP_SLVERR : `CIR_RESP_OKAY;
      s_axi_rdata  <= rd_bad ? 32'h0000_0000 : {24'h00_0000, rd_byte};
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  assign indirect_pointer_zero            = ptr;
  assign working_accumulator              = work_acc_reg;
  assign interrupt_control_main           = int_ctrl_main_reg;
  assign interrupt_control_edges_priority = int_ctrl_edge_reg;
  assign interrupt_control_external       = int_ctrl_ext_reg;

endmodule // cir_core_regs

// ==== tb/cir_core_regs_props.sv ====
// Purpose: Port checks of the core SFR bank
// Assumes: One clock domain, asynchronous active-low reset
// Notes:   Sees the top ports only; bound below
`timescale 1ns/1ps
`include "cir_map.vh"
module cir_core_regs_props (
  input wire                   clk_sys,
  input wire                   rst_n,
  input wire [`CIR_ADDR_W-1:0] s_axi_awaddr,
  input wire                   s_axi_awvalid,
  input wire                   s_axi_wvalid,
  input wire                   s_axi_bvalid,
  input wire                   s_axi_bready,
  input wire [`CIR_ADDR_W-1:0] s_axi_araddr,
  input wire                   s_axi_arvalid,
  input wire                   s_axi_rvalid,
  input wire [11:0]            indirect_pointer_zero,
  input wire [7:0]             working_accumulator
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  wire        wr_take = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
  wire        rd_take = s_axi_arvalid && !s_axi_rvalid && !wr_take;
  wire [15:0] addr    = wr_take ? s_axi_awaddr : s_axi_araddr;
  // Index 0 is plain memory, so it is a harmless idle value
  wire [11:0] idx     = ((wr_take || rd_take) && addr[15:14] == 2'b00) ?
                        addr[13:2] : 12'h000;
  ptr_plain_a: assert property (idx == `CIR_IND_PLAIN
    |=> $stable(indirect_pointer_zero)) else $error("plain access moved ptr");
  ptr_postinc_a: assert property (idx == `CIR_IND_POST_INC
    |=> indirect_pointer_zero == $past(indirect_pointer_zero) + 12'h001)
    else $error("post-increment wrong");
  ptr_postdec_a: assert property (idx == `CIR_IND_POST_DEC
    |=> indirect_pointer_zero == $past(indirect_pointer_zero) - 12'h001)
    else $error("post-decrement wrong");
  ptr_preinc_a: assert property (idx == `CIR_IND_PRE_INC
    |=> indirect_pointer_zero == $past(indirect_pointer_zero) + 12'h001)
    else $error("pre-increment wrong");
  offset_keep_a: assert property (idx == `CIR_IND_OFFSET
    |=> $stable(indirect_pointer_zero) && $stable(working_accumulator))
    else $error("offset access changed state");
  b_latency_a: assert property (wr_take |=> s_axi_bvalid)
    else $error("write answer late");
  b_single_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write answer repeated");
  r_latency_a: assert property (rd_take |=> s_axi_rvalid)
    else $error("read answer late");
endmodule // cir_core_regs_props

bind cir_core_regs cir_core_regs_props u_props (.clk_sys, .rst_n,
  .s_axi_awaddr, .s_axi_awvalid, .s_axi_wvalid, .s_axi_bvalid, .s_axi_bready,
  .s_axi_araddr, .s_axi_arvalid, .s_axi_rvalid, .indirect_pointer_zero,
  .working_accumulator);

// ==== tb/cir_core_regs_bench.sv ====
// Purpose: Self-checking bench of the core SFR bank over AXI4-Lite
// Assumes: Byte address is four times the register index
// Notes:   Responses ready tied high; answers checked from queues
`timescale 1ns/1ps
module cir_core_regs_bench;
  reg         clk_sys, rst_n, awvalid, wvalid, arvalid;
  reg  [15:0] awaddr, araddr;
  reg  [31:0] wdata;
  wire        awready, bvalid, arready, rvalid;
  wire [1:0]  bresp, rresp;
  wire [31:0] rdata;
  integer     n_mismatch, checked, seed, i;
  reg  [7:0]  d0, d1, d2, d3;
  reg  [3:0]  strb;
  reg  [27:0] t;
  wire [7:0]  irq_main, irq_edge, irq_ext;
  reg  [1:0]  exp_b[$];
  reg  [33:0] exp_r[$];
  // Index, reset value, readback after writing all ones
  function [27:0] tv(input integer k);
    case (k)
      0: tv = {12'hffb, 8'h20, 8'h3f};
      1: tv = {12'hff1, 8'hff, 8'hff};
      2: tv = {12'hff0, 8'hc0, 8'hff};
      3: tv = {12'hffc, 8'h00, 8'h1f};
      4: tv = {12'hfea, 8'h00, 8'h0f};
      5: tv = {12'hfff, 8'h00, 8'h1f};
      6: tv = {12'hff4, 8'h00, 8'hff};
      default: tv = {12'hff2, 8'h00, 8'hff};
    endcase
  endfunction
  cir_core_regs dut (
    .clk_sys(clk_sys), .rst_n(rst_n), .s_axi_awaddr(awaddr),
    .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(strb), .s_axi_wvalid(wvalid),
    .s_axi_wready(), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(1'b1), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1),
    .indirect_pointer_zero(), .working_accumulator(),
    .interrupt_control_main(irq_main),
    .interrupt_control_edges_priority(irq_edge),
    .interrupt_control_external(irq_ext));
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  function [15:0] ad(input [11:0] x);
    ad = {2'b00, x, 2'b00};
  endfunction
  task fail(input string m);
    begin
      n_mismatch = n_mismatch + 1;
      $display("Error at %0t: %0s", $time, m);
    end
  endtask
  task final_report;
    begin
      $display("checked %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask
  // Ready is looked at mid-cycle so the handshake edge is the next one
  task wait_hi(input integer s);
    integer n;
    reg     hit;
    begin
      hit = 1'b0;
      for (n = 0; n < 50 && !hit; n = n + 1) begin
        @(negedge clk_sys);
        hit = ((s == 0) ? awready : (s == 1) ? bvalid :
               (s == 2) ? arready : rvalid) === 1'b1;
      end
      if (!hit) begin
        fail("wait ran out");
        final_report;
      end
      @(posedge clk_sys);
    end
  endtask
  task wr(input [15:0] a, input [7:0] d, input [1:0] er);
    begin
      exp_b.push_back(er);
      awaddr <= a;
      wdata <= {24'h0, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      wait_hi(0);
      awvalid <= 1'b0;
      wvalid <= 1'b0;
      wait_hi(1);
    end
  endtask
  task rd(input [15:0] a, input [1:0] er, input [7:0] d);
    begin
      exp_r.push_back({er, 24'h0, d});
      araddr <= a;
      arvalid <= 1'b1;
      wait_hi(2);
      arvalid <= 1'b0;
      wait_hi(3);
    end
  endtask
  task cmp_r(input [33:0] e);
    begin
      checked = checked + 1;
      if ({rresp, rdata} !== e)
        fail("read data or response");
    end
  endtask
  task cmp_b(input [1:0] e);
    begin
      checked = checked + 1;
      if (bresp !== e)
        fail("write response");
    end
  endtask
  task cmp_p(input [7:0] v, input [7:0] e);
    begin
      checked = checked + 1;
      if (v !== e)
        fail("interrupt control port");
    end
  endtask
  // An answer with no note meets an impossible value and fails
  always @(posedge clk_sys) begin
    if (rst_n && rvalid === 1'b1)
      cmp_r(exp_r.size() ? exp_r.pop_front() : 34'h3_ffff_ffff);
    if (rst_n && bvalid === 1'b1)
      cmp_b(exp_b.size() ? exp_b.pop_front() : 2'h3);
  end
  initial begin
    seed = 52;
    n_mismatch = 0;
    checked = 0;
    rst_n = 1'b0;
    awvalid = 1'b0;
    wvalid = 1'b0;
    arvalid = 1'b0;
    awaddr = 16'h0000;
    araddr = 16'h0000;
    wdata = 32'h0;
    strb = 4'h1;
    repeat (6) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    for (i = 0; i < 8; i = i + 1) begin
      t = tv(i);
      rd(ad(t[27:16]), 2'h0, t[15:8]);
      wr(ad(t[27:16]), 8'hff, 2'h0);
      rd(ad(t[27:16]), 2'h0, t[7:0]);
    end
    cmp_p(irq_main, 8'hff);
    cmp_p(irq_edge, 8'hff);
    cmp_p(irq_ext, 8'hff);
    $display("test reset_and_access done");
    wr(ad(12'hf90), 8'h5a, 2'h0);
    rd(ad(12'hf90), 2'h0, 8'h00);
    wr(16'h4000, 8'h5a, 2'h2);
    rd(16'h4000, 2'h2, 8'h00);
    $display("test unmapped done");
    {d3, d2, d1, d0} = $random(seed);
    wr(ad(12'hfea), 8'h01, 2'h0);
    wr(ad(12'hfe9), 8'h23, 2'h0);
    wr(ad(12'hfef), d0, 2'h0);
    rd(ad(12'h123), 2'h0, d0);
    rd(ad(12'hfe9), 2'h0, 8'h23);
    wr(ad(12'hfee), d1, 2'h0);
    rd(ad(12'h123), 2'h0, d1);
    rd(ad(12'hfe9), 2'h0, 8'h24);
    wr(ad(12'h124), d3, 2'h0);
    rd(ad(12'hfef), 2'h0, d3);
    wr(ad(12'hfec), d2, 2'h0);
    rd(ad(12'h125), 2'h0, d2);
    rd(ad(12'hfe9), 2'h0, 8'h25);
    rd(ad(12'hfed), 2'h0, d2);
    rd(ad(12'hfe9), 2'h0, 8'h24);
    wr(ad(12'hfe8), 8'hff, 2'h0);
    rd(ad(12'hfeb), 2'h0, d1);
    wr(ad(12'hfe8), 8'h01, 2'h0);
    rd(ad(12'hfeb), 2'h0, d2);
    rd(ad(12'hfe9), 2'h0, 8'h24);
    rd(ad(12'hfe8), 2'h0, 8'h01);
    strb <= 4'h0;
    wr(ad(12'hfee), ~d3, 2'h0);
    strb <= 4'h1;
    rd(ad(12'h124), 2'h0, d3);
    rd(ad(12'hfe9), 2'h0, 8'h25);
    $display("test indirect done");
    wr(ad(12'hfea), 8'h0f, 2'h0);
    wr(ad(12'hfe9), 8'hff, 2'h0);
    wr(ad(12'hfee), d0, 2'h0);
    rd(ad(12'hfea), 2'h0, 8'h00);
    rd(ad(12'hfe9), 2'h0, 8'h00);
    $display("test wrap done");
    wr(ad(12'hff1), 8'h00, 2'h0);
    cmp_p(irq_edge, 8'h00);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    cmp_p(irq_main, 8'h00);
    cmp_p(irq_edge, 8'hff);
    cmp_p(irq_ext, 8'hc0);
    rd(ad(12'hfe8), 2'h0, 8'h00);
    rd(ad(12'hffb), 2'h0, 8'h20);
    $display("test second reset done");
    @(posedge clk_sys);
    final_report;
  end
endmodule // cir_core_regs_bench
